// ---- design/drive_io_assembly_mapper.sv ----
`timescale 1ns/10ps
module drive_io_assembly_mapper
    import io_map_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // Scanner cyclic data
    input  wire logic [7:0]    out_assembly_i,
    input  wire logic [7:0]    in_assembly_i,
    input  wire logic [31:0]   out_data_i,
    input  wire logic          out_valid_i,
    output logic [31:0]        in_data_o,
    // Drive internal status
    input  wire logic [15:0]   native_status_word_i,
    input  wire logic [15:0]   output_speed_word_i,
    input  wire logic          faulted_i,
    input  wire logic          warning_i,
    input  wire logic          running_fwd_i,
    input  wire logic          running_rev_i,
    input  wire logic          ready_i,
    input  wire logic          at_reference_i,
    input  wire logic [7:0]    drive_state_i,
    // Configuration
    input  wire access_level_t access_level_setting_i,
    input  wire logic          profile_selection_set_i,
    input  wire logic          profile_selection_val_i,
    input  wire logic          reference_source_one_net_i,
    input  wire logic          reference_switch_li3_i,
    input  wire logic          terminal_cmd_active_i,
    // Pins
    input  wire logic          logic_input_three_i,
    input  wire logic [1:0]    rate_switch_i,
    input  wire logic [5:0]    node_switch_i,
    // Internal command outputs
    output logic [15:0]        native_command_word_o,
    output logic [15:0]        speed_setpoint_word_o,
    output logic               profile_active_o,
    output logic               run_fwd_o,
    output logic               run_rev_o,
    output logic               fault_reset_o,
    output source_t            cmd_src_o,
    output source_t            ref_src_o,
    output logic               profile_selection_o,
    output data_rate_t         data_rate_o,
    output logic [5:0]         node_address_o
);

    //////////////////////////////////////////////////////////////////////////////
    cmd_sel_if sel_bus ();

    logic [1:0]  li3_sync_q,  li3_sync_d;
    logic [1:0]  rate_s1_q,   rate_s2_q;
    logic [5:0]  node_s1_q,   node_s2_q;
    logic        strap_done_q, strap_done_d;
    logic        net_ctrl_q,  net_ctrl_d;
    logic        net_ref_q,   net_ref_d;
    logic        prof_q,      prof_d;
    logic [31:0] in_data_d;
    logic [15:0] cmd_d, spd_d;
    logic        fwd_d, rev_d, rst_d, act_d;
    data_rate_t  rate_d;
    logic [5:0]  node_d;
    logic        profile_sel;

    //////////////////////////////////////////////////////////////////////////////
    // Synchronisers for the pins
    always_comb begin
        li3_sync_d = {li3_sync_q[0], logic_input_three_i};
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            li3_sync_q <= 2'h0;
        end else begin
            li3_sync_q <= li3_sync_d;
        end
    end

    // Switch synchronisers run through reset, so stage two already holds the pins at release
    always_ff @(posedge clk_i) begin
        rate_s1_q <= rate_switch_i;
        rate_s2_q <= rate_s1_q;
        node_s1_q <= node_switch_i;
        node_s2_q <= node_s1_q;
    end

    //////////////////////////////////////////////////////////////////////////////
    // Switches are caught once after reset release; later moves are ignored
    always_comb begin
        strap_done_d = strap_done_q;
        rate_d       = data_rate_o;
        node_d       = node_address_o;
        // Capture once, at the first edge after release
        if (!strap_done_q) begin
            strap_done_d = 1'b1;
            rate_d       = data_rate_t'(rate_s2_q);
            node_d       = node_s2_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Profile selection: combined by default, written by the setup port
    always_comb begin
        prof_d = prof_q;
        if (profile_selection_set_i) begin
            prof_d = profile_selection_val_i;
        end
    end
    assign profile_sel = prof_q;

    //////////////////////////////////////////////////////////////////////////////
    // Output assembly decode; assembly number comes only from the scanner
    always_comb begin
        cmd_d      = native_command_word_o;
        spd_d      = speed_setpoint_word_o;
        fwd_d      = run_fwd_o;
        rev_d      = run_rev_o;
        rst_d      = fault_reset_o;
        net_ctrl_d = net_ctrl_q;
        net_ref_d  = net_ref_q;
        act_d      = (out_assembly_i == ASM_BASIC_OUT) || (out_assembly_i == ASM_EXT_OUT) ||
                     (in_assembly_i == ASM_BASIC_IN) || (in_assembly_i == ASM_EXT_IN);
        if (out_valid_i) begin
            case (out_assembly_i)
                ASM_NATIVE_OUT: begin
                    cmd_d = out_data_i[15:0];
                    spd_d = out_data_i[31:16];
                end
                ASM_BASIC_OUT: begin
                    // Other bits of bytes 0 and 1 dropped
                    fwd_d = out_data_i[BIT_RUN_FWD];
                    rev_d = 1'b0;
                    rst_d = out_data_i[BIT_FLT_RST];
                    spd_d = {out_data_i[31:24], out_data_i[23:16]};
                    net_ctrl_d = 1'b1;
                    net_ref_d  = 1'b1;
                end
                ASM_EXT_OUT: begin
                    fwd_d      = out_data_i[BIT_RUN_FWD];
                    rev_d      = out_data_i[BIT_RUN_REV];
                    rst_d      = out_data_i[BIT_FLT_RST];
                    net_ctrl_d = out_data_i[BIT_NET_CTRL];
                    net_ref_d  = out_data_i[BIT_NET_REF];
                    spd_d      = {out_data_i[31:24], out_data_i[23:16]};
                end
                default: begin
                    cmd_d = native_command_word_o;
                end
            endcase
        end
        // Profile bits become internal drive-state commands and replace the native command word
        if (out_valid_i && (out_assembly_i == ASM_BASIC_OUT || out_assembly_i == ASM_EXT_OUT)) begin
            cmd_d = {12'h000, rst_d, rev_d, fwd_d, fwd_d | rev_d};
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Input assembly encode, unused bits zero
    always_comb begin
        in_data_d = ASM_ZERO;
        case (in_assembly_i)
            ASM_NATIVE_IN: begin
                in_data_d = {output_speed_word_i, native_status_word_i};
            end
            ASM_BASIC_IN: begin
                in_data_d[BIT_FAULTED]   = faulted_i;
                in_data_d[BIT_RUNNING_F] = running_fwd_i;
                in_data_d[31:16]         = output_speed_word_i;
            end
            ASM_EXT_IN: begin
                // Internal monitoring mapped back to the network view
                in_data_d[BIT_FAULTED]   = faulted_i;
                in_data_d[BIT_WARNING]   = warning_i;
                in_data_d[BIT_RUNNING_F] = running_fwd_i;
                in_data_d[BIT_RUNNING_R] = running_rev_i;
                in_data_d[BIT_READY]     = ready_i;
                in_data_d[BIT_CTRL_NET]  = sel_bus.cmd_src == SRC_NETWORK;
                in_data_d[BIT_REF_NET]   = sel_bus.ref_src == SRC_NETWORK;
                in_data_d[BIT_AT_REF]    = at_reference_i;
                in_data_d[15:8]          = drive_state_i;
                in_data_d[31:16]         = output_speed_word_i;
            end
            default: begin
                in_data_d = ASM_ZERO;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////////
    assign sel_bus.profile_active             = profile_active_o;
    assign sel_bus.fieldbus_control_request   = net_ctrl_q;
    assign sel_bus.fieldbus_reference_request = net_ref_q;
    assign sel_bus.switch_to_two              = li3_sync_q[1];

    channel_select u_sel (
        .access_level_setting_i     (access_level_setting_i),
        .profile_selection_i        (profile_sel),
        .reference_source_one_net_i (reference_source_one_net_i),
        .reference_switch_li3_i     (reference_switch_li3_i),
        .terminal_cmd_active_i      (terminal_cmd_active_i),
        .sel                        (sel_bus)
    );

    //////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            strap_done_q          <= 1'b0;
            data_rate_o           <= RATE_125K;
            node_address_o        <= NODE_RST;
            prof_q                <= PROFILE_RST;
            profile_selection_o   <= PROFILE_RST;
            net_ctrl_q            <= 1'b0;
            net_ref_q             <= 1'b0;
            native_command_word_o <= WORD_ZERO;
            speed_setpoint_word_o <= WORD_ZERO;
            run_fwd_o             <= 1'b0;
            run_rev_o             <= 1'b0;
            fault_reset_o         <= 1'b0;
            profile_active_o      <= 1'b0;
            in_data_o             <= ASM_ZERO;
            cmd_src_o             <= SRC_NONE;
            ref_src_o             <= SRC_NONE;
        end else begin
            strap_done_q          <= strap_done_d;
            data_rate_o           <= rate_d;
            node_address_o        <= node_d;
            prof_q                <= prof_d;
            profile_selection_o   <= prof_d;
            net_ctrl_q            <= net_ctrl_d;
            net_ref_q             <= net_ref_d;
            native_command_word_o <= cmd_d;
            speed_setpoint_word_o <= spd_d;
            run_fwd_o             <= fwd_d;
            run_rev_o             <= rev_d;
            fault_reset_o         <= rst_d;
            profile_active_o      <= act_d;
            in_data_o             <= in_data_d;
            cmd_src_o             <= sel_bus.cmd_src;
            ref_src_o             <= sel_bus.ref_src;
        end
    end
endmodule

// ---- design/io_map_pkg.sv ----
package io_map_pkg;
    // Assembly instance numbers
    localparam logic [7:0] ASM_NATIVE_OUT = 8'h64;
    localparam logic [7:0] ASM_NATIVE_IN  = 8'h65;
    localparam logic [7:0] ASM_BASIC_OUT  = 8'h14;
    localparam logic [7:0] ASM_EXT_OUT    = 8'h15;
    localparam logic [7:0] ASM_BASIC_IN   = 8'h46;
    localparam logic [7:0] ASM_EXT_IN     = 8'h47;

    // Byte 0 bit positions of the profile assemblies
    localparam int BIT_RUN_FWD   = 0;
    localparam int BIT_RUN_REV   = 1;
    localparam int BIT_FLT_RST   = 2;
    localparam int BIT_NET_CTRL  = 5;
    localparam int BIT_NET_REF   = 6;
    localparam int BIT_FAULTED   = 0;
    localparam int BIT_WARNING   = 1;
    localparam int BIT_RUNNING_F = 2;
    localparam int BIT_RUNNING_R = 3;
    localparam int BIT_READY     = 4;
    localparam int BIT_CTRL_NET  = 5;
    localparam int BIT_REF_NET   = 6;
    localparam int BIT_AT_REF    = 7;

    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [31:0] ASM_ZERO  = 32'h0000_0000;
    localparam logic [5:0]  NODE_RST  = 6'h3f;

    typedef enum logic [1:0] {
        ACCESS_L1,
        ACCESS_L2,
        ACCESS_L3,
        ACCESS_RSVD
    } access_level_t;

    typedef enum logic [1:0] {
        RATE_125K,
        RATE_250K,
        RATE_500K,
        RATE_BY_TOOL
    } data_rate_t;

    typedef enum logic [1:0] {
        SRC_NETWORK,
        SRC_TERMINAL,
        SRC_ANALOG_TWO,
        SRC_NONE
    } source_t;

    // Reset value of the profile selection: combined mode
    localparam logic PROFILE_SEPARATE = 1'b1;
    localparam logic PROFILE_COMBINED = 1'b0;
    localparam logic PROFILE_RST      = PROFILE_COMBINED;
endpackage

// ---- design/cmd_sel_if.sv ----
`timescale 1ns/10ps
interface cmd_sel_if;
    import io_map_pkg::*;
    logic          profile_active;
    logic          fieldbus_control_request;
    logic          fieldbus_reference_request;
    logic          switch_to_two;
    source_t       cmd_src;
    source_t       ref_src;
    modport mapper (output profile_active, output fieldbus_control_request,
                    output fieldbus_reference_request, output switch_to_two,
                    input cmd_src, input ref_src);
    modport sel    (input profile_active, input fieldbus_control_request,
                    input fieldbus_reference_request, input switch_to_two,
                    output cmd_src, output ref_src);
endinterface

// ---- design/channel_select.sv ----
`timescale 1ns/10ps
module channel_select
    import io_map_pkg::*;
(
    // Configuration
    input  wire access_level_t access_level_setting_i,
    input  wire logic          profile_selection_i,
    input  wire logic          reference_source_one_net_i,
    input  wire logic          reference_switch_li3_i,
    input  wire logic          terminal_cmd_active_i,
    // Link to mapper
    cmd_sel_if.sel             sel
);
    source_t cmd_d;
    source_t ref_d;

    always_comb begin
        cmd_d = SRC_NONE;
        ref_d = SRC_NONE;
        if (access_level_setting_i != ACCESS_L3) begin
            // Fixed priority, no switching: network first, then terminals
            if (reference_source_one_net_i) begin
                cmd_d = SRC_NETWORK;
            end else if (terminal_cmd_active_i) begin
                cmd_d = SRC_TERMINAL;
            end
            ref_d = cmd_d;
        end else begin
            if (reference_switch_li3_i && sel.switch_to_two) begin
                // Input three moves target and command together
                ref_d = SRC_ANALOG_TWO;
                cmd_d = SRC_TERMINAL;
            end else if (reference_source_one_net_i) begin
                ref_d = SRC_NETWORK;
                cmd_d = SRC_NETWORK;
            end
            if (profile_selection_i == PROFILE_SEPARATE && sel.profile_active) begin
                // Separate sources only at the top access level
                cmd_d = sel.fieldbus_control_request ? SRC_NETWORK : SRC_TERMINAL;
                ref_d = sel.fieldbus_reference_request ? SRC_NETWORK : SRC_ANALOG_TWO;
            end
        end
    end

    assign sel.cmd_src = cmd_d;
    assign sel.ref_src = ref_d;
endmodule

// ---- tb/drive_io_assembly_mapper_assertions.sv ----
`timescale 1ns/10ps
module drive_io_assembly_mapper_assertions (
    // Clock and reset
    input wire logic                        clk_i, sys_rst_i,
    // Scanner side
    input wire logic [7:0]                  out_assembly_i, in_assembly_i,
    input wire logic [31:0]                 out_data_i, in_data_o,
    input wire logic                        out_valid_i,
    // Drive status
    input wire logic [15:0]                 native_status_word_i, output_speed_word_i,
    input wire logic                        faulted_i, warning_i, running_fwd_i, running_rev_i, ready_i,
    input wire logic                        at_reference_i,
    input wire logic [7:0]                  drive_state_i,
    input wire io_map_pkg::access_level_t   access_level_setting_i,
    // Commands
    input wire logic [15:0]                 native_command_word_o, speed_setpoint_word_o,
    input wire logic                        profile_active_o, run_fwd_o, run_rev_o, fault_reset_o,
    input wire io_map_pkg::source_t         cmd_src_o, ref_src_o,
    input wire io_map_pkg::data_rate_t      data_rate_o,
    input wire logic [5:0]                  node_address_o
);
    import io_map_pkg::*;
    logic [2:0]  cnt_q, cnt_d;
    logic [31:0] d_q, d_d;
    logic        is_prof, known_out;
    assign is_prof = out_assembly_i inside {ASM_BASIC_OUT, ASM_EXT_OUT} || in_assembly_i inside {ASM_BASIC_IN, ASM_EXT_IN};
    assign known_out = out_assembly_i inside {ASM_NATIVE_OUT, ASM_BASIC_OUT, ASM_EXT_OUT};
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        cnt_d = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
        d_d = out_data_i;
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= 3'h0;
            d_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_d;
            d_q <= d_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_take(logic [7:0] n);
        out_valid_i && out_assembly_i == n;
    endsequence
    sequence s_show(logic [7:0] n);
        in_assembly_i == n && $stable(in_assembly_i);
    endsequence
    property p_native_out;
        s_take(ASM_NATIVE_OUT) |=> {speed_setpoint_word_o, native_command_word_o} == d_q;
    endproperty
    a_native_out: assert property (p_native_out) else $error("native command not taken");
    property p_native_in;
        s_show(ASM_NATIVE_IN) |=> in_data_o == {$past(output_speed_word_i), $past(native_status_word_i)};
    endproperty
    a_native_in: assert property (p_native_in) else $error("native status wrong");
    property p_profile;
        out_valid_i && $stable(out_assembly_i) && $stable(in_assembly_i) |=> profile_active_o == $past(is_prof);
    endproperty
    a_profile: assert property (p_profile) else $error("profile flag wrong");
    property p_basic_out;
        s_take(ASM_BASIC_OUT) |=> run_fwd_o == d_q[0] && !run_rev_o && fault_reset_o == d_q[2]
            && speed_setpoint_word_o == d_q[31:16] && native_command_word_o == {12'h0, d_q[2], 1'b0, d_q[0], d_q[0]};
    endproperty
    a_basic_out: assert property (p_basic_out) else $error("basic output decode wrong");
    property p_ext_out;
        s_take(ASM_EXT_OUT) |=> {run_fwd_o, run_rev_o, fault_reset_o} == {d_q[0], d_q[1], d_q[2]}
            && native_command_word_o == {12'h0, d_q[2], d_q[1], d_q[0], d_q[0] | d_q[1]};
    endproperty
    a_ext_out: assert property (p_ext_out) else $error("extended output decode wrong");
    property p_basic_in;
        s_show(ASM_BASIC_IN) |=> in_data_o == {$past(output_speed_word_i), 13'h0, $past(running_fwd_i), 1'b0,
            $past(faulted_i)};
    endproperty
    a_basic_in: assert property (p_basic_in) else $error("basic input wrong");
    property p_ext_in;
        s_show(ASM_EXT_IN) |=> (in_data_o & 32'hffff_ff9f) == {$past(output_speed_word_i), $past(drive_state_i),
            $past(at_reference_i), 2'b00, $past(ready_i), $past(running_rev_i), $past(running_fwd_i),
            $past(warning_i), $past(faulted_i)};
    endproperty
    a_ext_in: assert property (p_ext_in) else $error("extended input wrong");
    property p_net_flags;
        in_assembly_i == ASM_EXT_IN |=> in_data_o[BIT_CTRL_NET] == (cmd_src_o == SRC_NETWORK)
            && in_data_o[BIT_REF_NET] == (ref_src_o == SRC_NETWORK);
    endproperty
    a_net_flags: assert property (p_net_flags) else $error("network source flags wrong");
    property p_hold;
        !out_valid_i || !known_out |=> $stable(run_fwd_o) && $stable(run_rev_o) && $stable(fault_reset_o)
            && $stable(speed_setpoint_word_o) && $stable(native_command_word_o);
    endproperty
    a_hold: assert property (p_hold) else $error("command changed without valid assembly");
    property p_switches;
        cnt_q == 3'h7 |-> $stable(node_address_o) && $stable(data_rate_o);
    endproperty
    a_switches: assert property (p_switches) else $error("switch value changed after capture");
    property p_shared;
        (access_level_setting_i != ACCESS_L3) [*3] |-> cmd_src_o == ref_src_o;
    endproperty
    a_shared: assert property (p_shared) else $error("split sources below L3");
endmodule

// ---- tb/scanner_model.sv ----
`timescale 1ns/10ps
module scanner_model (
    // Clock
    input  wire logic   clk_i,
    // Cyclic exchange
    output logic [7:0]  out_assembly_o,
    output logic [7:0]  in_assembly_o,
    output logic [31:0] out_data_o,
    output logic        out_valid_o
);
    initial begin
        out_assembly_o = 8'h64;
        in_assembly_o = 8'h65;
        out_data_o = 32'h0000_0000;
        out_valid_o = 1'b0;
    end
    // Only the scanner picks the assembly pair
    task automatic send(input logic [7:0] oa, input logic [7:0] ia, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        out_assembly_o = oa;
        in_assembly_o = ia;
        out_data_o = d;
        out_valid_o = 1'b1;
        @(posedge clk_i);
        #1;
        out_valid_o = 1'b0;
        // Stale data is inverted so a missed sample cannot look right
        out_data_o = ~d;
    endtask
endmodule

// ---- tb/test_drive_io_assembly_mapper.sv ----
`timescale 1ns/10ps
module test_drive_io_assembly_mapper;
    import io_map_pkg::*;
    logic          clk_i, sys_rst_i, pset, pval, net1, term, li3sw, li3, pact, rf, rr, frs, psel, fw, rv, fr;
    logic [7:0]    oa, ia, dst, a, b;
    logic [31:0]   od, in_data, r, d, m_in, seed = 32'hb6e9a34f;
    logic [15:0]   nsw, osw, ncw, ssw, m_ncw, m_sp;
    logic [5:0]    flg, node, n_exp;
    logic [1:0]    rate;
    logic          ov, m_nc, m_nr, m_act;
    access_level_t lvl;
    source_t       csrc, rsrc;
    data_rate_t    drate;
    logic [5:0]    naddr;
    int            n_fail = 0, num_checks = 0, cyc = 0;
    logic [7:0]    oa_tab[4] = '{ASM_NATIVE_OUT, ASM_BASIC_OUT, ASM_EXT_OUT, 8'h33};
    logic [7:0]    ia_tab[4] = '{ASM_NATIVE_IN, ASM_BASIC_IN, ASM_EXT_IN, 8'h22};
    scanner_model scanner (.clk_i(clk_i), .out_assembly_o(oa), .in_assembly_o(ia), .out_data_o(od), .out_valid_o(ov));
    drive_io_assembly_mapper uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .out_assembly_i(oa), .in_assembly_i(ia),
        .out_data_i(od), .out_valid_i(ov), .in_data_o(in_data), .native_status_word_i(nsw),
        .output_speed_word_i(osw), .faulted_i(flg[0]), .warning_i(flg[1]), .running_fwd_i(flg[2]),
        .running_rev_i(flg[3]), .ready_i(flg[4]), .at_reference_i(flg[5]), .drive_state_i(dst),
        .access_level_setting_i(lvl), .profile_selection_set_i(pset), .profile_selection_val_i(pval),
        .reference_source_one_net_i(net1), .reference_switch_li3_i(li3sw), .terminal_cmd_active_i(term),
        .logic_input_three_i(li3), .rate_switch_i(rate), .node_switch_i(node), .native_command_word_o(ncw),
        .speed_setpoint_word_o(ssw), .profile_active_o(pact), .run_fwd_o(rf), .run_rev_o(rr),
        .fault_reset_o(frs), .cmd_src_o(csrc), .ref_src_o(rsrc), .profile_selection_o(psel),
        .data_rate_o(drate), .node_address_o(naddr));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected {command, reference} source pair; p is separate mode with a profile assembly selected
    function automatic logic [3:0] src_model(access_level_t l, logic n, logic t, logic s, logic x, logic p, logic c,
                                             logic f);
        if (l != ACCESS_L3) begin
            return n ? {SRC_NETWORK, SRC_NETWORK} : t ? {SRC_TERMINAL, SRC_TERMINAL} : {SRC_NONE, SRC_NONE};
        end
        if (p) return {c ? SRC_NETWORK : SRC_TERMINAL, f ? SRC_NETWORK : SRC_ANALOG_TWO};
        if (s && x) return {SRC_TERMINAL, SRC_ANALOG_TWO};
        return n ? {SRC_NETWORK, SRC_NETWORK} : {SRC_NONE, SRC_NONE};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic do_reset();
        sys_rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        #1;
        check(32'(naddr), 32'(NODE_RST));
        check(32'(drate), 32'(RATE_125K));
        check(32'(psel), 32'(PROFILE_COMBINED));
        sys_rst_i = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        {pset, pval, net1, term, li3sw, li3, nsw, osw, flg, dst} = '0;
        lvl = ACCESS_L1;
        rate = 2'h0;
        node = 6'h00;
        sys_rst_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rate = 2'(i);
            node = 6'(rnd());
            n_exp = node;
            do_reset();
            repeat (5) @(posedge clk_i);
            #1;
            check(32'(drate), 32'(i));
            check(32'(naddr), 32'(n_exp));
            rate = ~rate;
            node = ~node;
            repeat (5) @(posedge clk_i);
            #1;
            check(32'(drate), 32'(i));
            check(32'(naddr), 32'(n_exp));
        end
        m_ncw = 16'h0;
        m_sp = 16'h0;
        {m_nc, m_nr, m_act} = 3'h0;
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            a = oa_tab[r[1:0]];
            b = ia_tab[r[3:2]];
            {nsw, osw} = rnd();
            flg = r[9:4];
            dst = r[17:10];
            d = rnd();
            scanner.send(a, b, d);
            fw = d[0];
            rv = (a == ASM_EXT_OUT) & d[1];
            fr = d[2];
            if (a == ASM_NATIVE_OUT) {m_sp, m_ncw} = d;
            if (a == ASM_BASIC_OUT || a == ASM_EXT_OUT) begin
                m_ncw = {12'h0, fr, rv, fw, fw | rv};
                m_sp = d[31:16];
                check(32'({rf, rr, frs}), 32'({fw, rv, fr}));
            end
            if (a == ASM_BASIC_OUT) {m_nc, m_nr} = 2'b11;
            if (a == ASM_EXT_OUT) {m_nc, m_nr} = {d[5], d[6]};
            m_act = a inside {ASM_BASIC_OUT, ASM_EXT_OUT} || b inside {ASM_BASIC_IN, ASM_EXT_IN};
            case (b)
                ASM_NATIVE_IN: m_in = {osw, nsw};
                ASM_BASIC_IN:  m_in = {osw, 13'h0, flg[2], 1'b0, flg[0]};
                ASM_EXT_IN:    m_in = {osw, dst, flg[5], 2'b00, flg[4:0]};
                default:       m_in = 32'h0;
            endcase
            check(in_data & (b == ASM_EXT_IN ? 32'hffff_ff9f : 32'hffff_ffff), m_in);
            check(32'({ssw, ncw}), 32'({m_sp, m_ncw}));
            check(32'(pact), 32'(m_act));
        end
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            lvl = access_level_t'(r[1:0] == 2'h3 ? 2'h2 : r[1:0]);
            net1 = r[2] | (lvl == ACCESS_L3);
            {term, li3sw, li3} = r[5:3];
            pval = r[6];
            pset = 1'b1;
            @(posedge clk_i);
            #1;
            pset = 1'b0;
            repeat (6) @(posedge clk_i);
            #1;
            check(32'(psel), 32'(pval));
            d = 32'(src_model(lvl, net1, term, li3sw, li3, pval & m_act, m_nc, m_nr));
            check(32'({csrc, rsrc}), d);
        end
        close_out();
    end
endmodule
bind drive_io_assembly_mapper drive_io_assembly_mapper_assertions chk (.clk_i, .sys_rst_i, .out_assembly_i,
    .in_assembly_i, .out_data_i, .in_data_o, .out_valid_i, .native_status_word_i, .output_speed_word_i, .faulted_i,
    .warning_i, .running_fwd_i, .running_rev_i, .ready_i, .at_reference_i, .drive_state_i, .access_level_setting_i,
    .native_command_word_o, .speed_setpoint_word_o, .profile_active_o, .run_fwd_o, .run_rev_o, .fault_reset_o,
    .cmd_src_o, .ref_src_o, .data_rate_o, .node_address_o);
